// file: lupc_core_model.sv
// Headend core model: learning request and received frame stream
`timescale 1ns/1ps
`default_nettype none
module lupc_core_model (
  input  wire logic        clk_in,
  output logic             hdr_valid_out,
  output logic      [15:0] src_port_out,
  output logic             byte_valid_out,
  output logic      [7:0]  byte_out,
  output logic             first_out,
  output logic             last_out,
  output logic             in_udp_out,
  output logic             is_ctrl_out,
  output logic      [15:0] csum_out
);
  initial begin
    {hdr_valid_out, src_port_out, byte_valid_out, byte_out} = '0;
    {first_out, last_out, in_udp_out, is_ctrl_out, csum_out} = '0;
  end
  // Inverted reflected CRC over a frame
  function automatic logic [31:0] fcs(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hffffffff;
    foreach (q[i]) begin
      c = c ^ {24'h000000, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction
  // First request from an ephemeral port; released port shows inverse
  task automatic sccrq(input logic [15:0] port);
    hdr_valid_out <= 1'b1;
    src_port_out  <= port;
    @(posedge clk_in);
    hdr_valid_out <= 1'b0;
    src_port_out  <= ~port;
    @(posedge clk_in);
  endtask
  // Frame then its check bytes, low byte first; bad flips one bit
  task automatic frame(input logic [7:0] q[$], input logic ctrl, input logic bad);
    logic [31:0] c;
    int          n;
    n = q.size();
    c = fcs(q) ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) q.push_back(c[8*i +: 8]);
    foreach (q[i]) begin
      byte_valid_out <= 1'b1;
      byte_out       <= q[i];
      first_out      <= (i == 0);
      last_out       <= (i == n + 3);
      in_udp_out     <= (i < n);
      is_ctrl_out    <= ctrl;
      csum_out       <= {q[0], q[1]};
      @(posedge clk_in);
    end
    byte_valid_out <= 1'b0;
    byte_out       <= ~q[n + 3];
    last_out       <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: lupc_pkg.sv
// Constants, types and helper functions for the UDP port and checksum block
package lupc_pkg;

  // Well-known L2TPv3 UDP port, 1701
  localparam logic [15:0] LUPC_WELL_KNOWN_PORT = 16'h06a5;

  // Register byte offsets
  localparam logic [7:0] LUPC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] LUPC_OFF_PORTS  = 8'h04;
  localparam logic [7:0] LUPC_OFF_MCAST  = 8'h08;
  localparam logic [7:0] LUPC_OFF_SEL    = 8'h0c;
  localparam logic [7:0] LUPC_OFF_SPORT  = 8'h10;
  localparam logic [7:0] LUPC_OFF_SFLAG  = 8'h14;
  localparam logic [7:0] LUPC_OFF_STATUS = 8'h18;

  // Field positions
  localparam int LUPC_BIT_CAPABLE = 0;
  localparam int LUPC_BIT_AUTH    = 1;
  localparam int LUPC_BIT_IPV6    = 2;
  localparam int LUPC_BIT_ACTIVE  = 8;
  localparam int LUPC_BIT_OWN_V   = 0;
  localparam int LUPC_BIT_CORE_V  = 1;
  localparam int LUPC_BIT_REJECT  = 0;

  // Reset values; empty multicast range until configured
  localparam logic [15:0] LUPC_MCAST_LO_RST = 16'hffff;
  localparam logic [15:0] LUPC_MCAST_HI_RST = 16'h0000;

  // Session table size
  localparam int LUPC_SESS_NUM = 8;
  localparam int LUPC_SESS_W   = 3;

  // Frame check sequence, reflected form
  localparam logic [31:0] LUPC_CRC_POLY    = 32'hedb88320;
  localparam logic [31:0] LUPC_CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] LUPC_CRC_RESIDUE = 32'hdebb20e3;

  typedef enum logic [1:0] {
    LUPC_KIND_SCCRP,
    LUPC_KIND_CTRL,
    LUPC_KIND_UP_DATA,
    LUPC_KIND_DS_RETURN
  } lupc_kind_t;

  typedef enum logic {LUPC_BUS_IDLE, LUPC_BUS_ACK} lupc_bus_t;

  function automatic logic [31:0] lupc_crc_byte(input logic [31:0] crc, input logic [7:0] b);
    logic [31:0] c;
    c = crc ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ LUPC_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [15:0] lupc_fold(input logic [31:0] s);
    logic [31:0] t;
    t = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
    t = {16'h0000, t[15:0]} + {16'h0000, t[31:16]};
    return t[15:0];
  endfunction

  function automatic logic lupc_in_range(input logic [15:0] p, input logic [15:0] lo,
                                         input logic [15:0] hi);
    return (p >= lo) && (p <= hi);
  endfunction

  function automatic logic [31:0] lupc_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// file: lupc_top.sv
// Remote node UDP port selection, UDP checksum and frame check logic
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module lupc_top
  import lupc_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   ce_in,
  input  wire logic [7:0]             avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic      [31:0]            avs_readdata_out,
  output logic                        avs_waitrequest_out,
  input  wire logic                   rx_hdr_valid_in,
  input  wire logic                   rx_is_sccrq_in,
  input  wire logic                   rx_has_udp_in,
  input  wire logic [15:0]            rx_src_port_in,
  input  wire logic                   rx_byte_valid_in,
  input  wire logic [7:0]             rx_byte_in,
  input  wire logic                   rx_first_in,
  input  wire logic                   rx_last_in,
  input  wire logic                   rx_in_udp_in,
  input  wire logic                   rx_is_ctrl_in,
  input  wire logic [15:0]            rx_csum_in,
  output logic                        rx_done_out,
  output logic                        rx_discard_out,
  input  wire logic                   tx_req_in,
  input  wire logic [1:0]             tx_kind_in,
  input  wire logic [LUPC_SESS_W-1:0] tx_sess_in,
  output logic                        tx_hdr_valid_out,
  output logic                        tx_udp_out,
  output logic      [15:0]            tx_dst_port_out,
  output logic      [15:0]            tx_src_port_out,
  input  wire logic                   tx_byte_valid_in,
  input  wire logic [7:0]             tx_byte_in,
  input  wire logic                   tx_first_in,
  input  wire logic                   tx_last_in,
  input  wire logic                   tx_in_udp_in,
  input  wire logic                   tx_is_ctrl_in,
  output logic                        tx_done_out,
  output logic      [15:0]            tx_csum_out,
  output logic      [31:0]            tx_fcs_out
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  lupc_bus_t               bus_state;
  logic                    udp_capable;
  logic                    auth_on;
  logic                    ipv6;
  logic                    udp_active;
  logic [15:0]             init_port;
  logic [15:0]             resp_port;
  logic [15:0]             mcast_lo;
  logic [15:0]             mcast_hi;
  logic [LUPC_SESS_W-1:0]  sess_sel;
  logic [15:0]             own_port  [LUPC_SESS_NUM];
  logic [15:0]             core_port [LUPC_SESS_NUM];
  logic [LUPC_SESS_NUM-1:0] own_valid;
  logic [LUPC_SESS_NUM-1:0] core_valid;
  logic                    reject;
  logic [15:0]             discard_cnt;
  logic [31:0]             rx_sum;
  logic [31:0]             rx_crc;
  logic                    rx_odd;
  logic [31:0]             tx_sum;
  logic [31:0]             tx_crc;
  logic                    tx_odd;

  logic [31:0] readv;
  logic [31:0] wv;
  logic        wr_go;
  logic        rx_go;
  logic        tx_go;
  logic        rx_discard;
  logic        rx_zero;
  logic [31:0] next_rx_sum;
  logic [31:0] next_rx_crc;
  logic        next_rx_odd;
  logic [31:0] next_tx_sum;
  logic [31:0] next_tx_crc;
  logic        next_tx_odd;
  logic [15:0] tx_fold;

  //////////////////////////////////////////////////////////////////////////////
  // Register bus

  assign wr_go = ce_in && avs_write_in && !avs_waitrequest_out;
  assign wv    = lupc_merge(readv, avs_writedata_in, avs_byteenable_in);

  always_comb begin
    readv = 32'h00000000;
    case (avs_address_in)
      LUPC_OFF_CTRL: begin
        readv[LUPC_BIT_CAPABLE] = udp_capable;
        readv[LUPC_BIT_AUTH]    = auth_on;
        readv[LUPC_BIT_IPV6]    = ipv6;
        readv[LUPC_BIT_ACTIVE]  = udp_active;
      end
      LUPC_OFF_PORTS:  readv = {init_port, resp_port};
      LUPC_OFF_MCAST:  readv = {mcast_hi, mcast_lo};
      LUPC_OFF_SEL:    readv[LUPC_SESS_W-1:0] = sess_sel;
      LUPC_OFF_SPORT:  readv = {core_port[sess_sel], own_port[sess_sel]};
      LUPC_OFF_SFLAG: begin
        readv[LUPC_BIT_OWN_V]  = own_valid[sess_sel];
        readv[LUPC_BIT_CORE_V] = core_valid[sess_sel];
      end
      LUPC_OFF_STATUS: readv = {discard_cnt, 15'h0000, reject};
      default:         readv = 32'h00000000;
    endcase
  end

  // One wait cycle, then the answer stands for exactly one cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_state           <= LUPC_BUS_IDLE;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h00000000;
    end else if (ce_in) begin
      case (bus_state)
        LUPC_BUS_IDLE: begin
          if (avs_read_in || avs_write_in) begin
            bus_state           <= LUPC_BUS_ACK;
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out    <= readv;
          end
        end
        LUPC_BUS_ACK: begin
          bus_state           <= LUPC_BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
        default: begin
          bus_state           <= LUPC_BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // Configuration, and the responder port of the control port pair
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      udp_capable <= 1'b0;
      auth_on     <= 1'b0;
      ipv6        <= 1'b0;
      resp_port   <= LUPC_WELL_KNOWN_PORT;
      mcast_lo    <= LUPC_MCAST_LO_RST;
      mcast_hi    <= LUPC_MCAST_HI_RST;
      sess_sel    <= '0;
    end else if (wr_go) begin
      case (avs_address_in)
        LUPC_OFF_CTRL: begin
          udp_capable <= wv[LUPC_BIT_CAPABLE];
          auth_on     <= wv[LUPC_BIT_AUTH];
          ipv6        <= wv[LUPC_BIT_IPV6];
        end
        LUPC_OFF_PORTS: begin
          if (!lupc_in_range(wv[15:0], mcast_lo, mcast_hi)) begin
            resp_port <= wv[15:0];
          end
        end
        LUPC_OFF_MCAST: begin
          mcast_lo <= wv[15:0];
          mcast_hi <= wv[31:16];
        end
        LUPC_OFF_SEL: sess_sel <= wv[LUPC_SESS_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Learning the initiator port also switches UDP headers on
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      init_port  <= LUPC_WELL_KNOWN_PORT;
      udp_active <= 1'b0;
    end else if (ce_in && rx_hdr_valid_in && rx_is_sccrq_in && rx_has_udp_in && udp_capable) begin
      init_port  <= rx_src_port_in;
      udp_active <= 1'b1;
    end
  end

  // Session table; own ports in the multicast range are refused
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      own_valid  <= '0;
      core_valid <= '0;
      for (int i = 0; i < LUPC_SESS_NUM; i++) begin
        own_port[i]  <= 16'h0000;
        core_port[i] <= 16'h0000;
      end
    end else if (wr_go) begin
      if (avs_address_in == LUPC_OFF_SPORT) begin
        core_port[sess_sel] <= wv[31:16];
        if (!lupc_in_range(wv[15:0], mcast_lo, mcast_hi)) begin
          own_port[sess_sel] <= wv[15:0];
        end
      end
      if (avs_address_in == LUPC_OFF_SFLAG) begin
        own_valid[sess_sel]  <= wv[LUPC_BIT_OWN_V];
        core_valid[sess_sel] <= wv[LUPC_BIT_CORE_V];
      end
    end
  end

  // Refusal flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reject <= 1'b0;
    end else if (wr_go) begin
      if (((avs_address_in == LUPC_OFF_SPORT) || (avs_address_in == LUPC_OFF_PORTS))
          && lupc_in_range(wv[15:0], mcast_lo, mcast_hi)) begin
        reject <= 1'b1;
      end else if (avs_address_in == LUPC_OFF_STATUS
                   && avs_byteenable_in[0] && avs_writedata_in[LUPC_BIT_REJECT]) begin
        reject <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outgoing header ports

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_hdr_valid_out <= 1'b0;
      tx_udp_out       <= 1'b0;
      tx_dst_port_out  <= 16'h0000;
      tx_src_port_out  <= 16'h0000;
    end else if (ce_in) begin
      tx_hdr_valid_out <= tx_req_in;
      if (tx_req_in) begin
        tx_udp_out <= udp_active;
        case (lupc_kind_t'(tx_kind_in))
          LUPC_KIND_SCCRP, LUPC_KIND_CTRL: begin
            tx_dst_port_out <= init_port;
            tx_src_port_out <= resp_port;
          end
          LUPC_KIND_UP_DATA: begin
            tx_dst_port_out <= core_valid[tx_sess_in] ? core_port[tx_sess_in] : init_port;
            tx_src_port_out <= own_valid[tx_sess_in] ? own_port[tx_sess_in] : resp_port;
          end
          default: begin
            tx_dst_port_out <= core_valid[tx_sess_in] ? core_port[tx_sess_in] : init_port;
            tx_src_port_out <= own_valid[tx_sess_in] ? own_port[tx_sess_in] : resp_port;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checksum and frame check accumulation

  assign rx_go = ce_in && rx_byte_valid_in;
  assign tx_go = ce_in && tx_byte_valid_in;

  // First byte of a pair is the high half of a 16-bit word
  always_comb begin
    next_rx_sum = rx_first_in ? 32'h00000000 : rx_sum;
    next_rx_odd = rx_first_in ? 1'b0 : rx_odd;
    next_rx_crc = lupc_crc_byte(rx_first_in ? LUPC_CRC_INIT : rx_crc, rx_byte_in);
    if (rx_in_udp_in) begin
      next_rx_sum = next_rx_sum + (next_rx_odd ? {24'h000000, rx_byte_in}
                                               : {16'h0000, rx_byte_in, 8'h00});
      next_rx_odd = !next_rx_odd;
    end
    next_tx_sum = tx_first_in ? 32'h00000000 : tx_sum;
    next_tx_odd = tx_first_in ? 1'b0 : tx_odd;
    next_tx_crc = lupc_crc_byte(tx_first_in ? LUPC_CRC_INIT : tx_crc, tx_byte_in);
    if (tx_in_udp_in) begin
      next_tx_sum = next_tx_sum + (next_tx_odd ? {24'h000000, tx_byte_in}
                                               : {16'h0000, tx_byte_in, 8'h00});
      next_tx_odd = !next_tx_odd;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_sum <= 32'h00000000;
      rx_crc <= LUPC_CRC_INIT;
      rx_odd <= 1'b0;
      tx_sum <= 32'h00000000;
      tx_crc <= LUPC_CRC_INIT;
      tx_odd <= 1'b0;
    end else begin
      if (rx_go) begin
        rx_sum <= next_rx_sum;
        rx_crc <= next_rx_crc;
        rx_odd <= next_rx_odd;
      end
      if (tx_go) begin
        tx_sum <= next_tx_sum;
        tx_crc <= next_tx_crc;
        tx_odd <= next_tx_odd;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive verdict

  assign rx_zero = (rx_csum_in == 16'h0000);

  // Data over IPv4 skips nonzero checksums to save a compare path
  always_comb begin
    rx_discard = (next_rx_crc != LUPC_CRC_RESIDUE);
    if (rx_is_ctrl_in) begin
      if (rx_zero) begin
        rx_discard = rx_discard || !auth_on;
      end else if (lupc_fold(next_rx_sum) != 16'hffff) begin
        rx_discard = 1'b1;
      end
    end else if (!rx_zero && ipv6 && lupc_fold(next_rx_sum) != 16'hffff) begin
      rx_discard = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_done_out    <= 1'b0;
      rx_discard_out <= 1'b0;
      discard_cnt    <= 16'h0000;
    end else if (ce_in) begin
      rx_done_out <= rx_byte_valid_in && rx_last_in;
      if (rx_byte_valid_in && rx_last_in) begin
        rx_discard_out <= rx_discard;
        if (rx_discard) begin
          discard_cnt <= discard_cnt + 16'h0001;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit checksum and frame check

  assign tx_fold = ~lupc_fold(next_tx_sum);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_done_out <= 1'b0;
      tx_csum_out <= 16'h0000;
      tx_fcs_out  <= 32'h00000000;
    end else if (ce_in) begin
      tx_done_out <= tx_byte_valid_in && tx_last_in;
      if (tx_byte_valid_in && tx_last_in) begin
        tx_fcs_out <= ~next_tx_crc;
        if (!tx_is_ctrl_in || (auth_on && !ipv6)) begin
          tx_csum_out <= 16'h0000;
        end else begin
          // A computed zero is sent as all ones, zero means no checksum
          tx_csum_out <= (tx_fold == 16'h0000) ? 16'hffff : tx_fold;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in || !ce_in);

  sequence bus_req_s;
    (avs_read_in || avs_write_in) && bus_state == LUPC_BUS_IDLE;
  endsequence
  sequence bus_ans_s;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  bus_answer_a: assert property (bus_req_s |=> bus_ans_s)
    else $error("bus answer not one cycle after request");

  port_learn_a: assert property (
    rx_hdr_valid_in && rx_is_sccrq_in && rx_has_udp_in && udp_capable
    |=> init_port == $past(rx_src_port_in) && udp_active)
    else $error("initiator port not learned");

  ctrl_ports_a: assert property (
    tx_req_in && tx_kind_in != LUPC_KIND_UP_DATA && tx_kind_in != LUPC_KIND_DS_RETURN
    |=> tx_hdr_valid_out && tx_dst_port_out == $past(init_port)
        && tx_src_port_out == $past(resp_port))
    else $error("control ports wrong");

  up_fallback_a: assert property (
    tx_req_in && tx_kind_in == LUPC_KIND_UP_DATA && !core_valid[tx_sess_in]
    |=> tx_dst_port_out == $past(init_port))
    else $error("upstream fallback port wrong");

  mcast_refuse_a: assert property (
    wr_go && avs_address_in == LUPC_OFF_SPORT && lupc_in_range(wv[15:0], mcast_lo, mcast_hi)
    |=> own_port[$past(sess_sel)] == $past(own_port[sess_sel]) && reject)
    else $error("multicast range port accepted");

  ctrl_zero_drop_a: assert property (
    rx_byte_valid_in && rx_last_in && rx_is_ctrl_in && !auth_on && rx_zero
    |=> rx_done_out && rx_discard_out ##1 !rx_done_out)
    else $error("zero control checksum accepted");

  data_zero_tx_a: assert property (
    tx_byte_valid_in && tx_last_in && !tx_is_ctrl_in |=> tx_done_out && tx_csum_out == 16'h0000)
    else $error("data checksum not zero");

  v6_ctrl_csum_a: assert property (
    tx_byte_valid_in && tx_last_in && tx_is_ctrl_in && ipv6
    |=> tx_csum_out != 16'h0000 && tx_done_out)
    else $error("IPv6 control checksum missing");

  data_zero_rx_a: assert property (
    rx_byte_valid_in && rx_last_in && !rx_is_ctrl_in && rx_zero
    && next_rx_crc == LUPC_CRC_RESIDUE |=> !rx_discard_out)
    else $error("zero data checksum dropped");

endmodule

`default_nettype wire

// file: lupc_top_tb_top.sv
// Self-checking bench for the UDP port and checksum block
`timescale 1ns/1ps
`default_nettype none
module lupc_top_tb_top
  import lupc_pkg::*;
;
  typedef logic [7:0] lupc_bytes_t[$];
  logic        clk_in, rst_in, avs_read, avs_write, avs_wait, tx_req, tx_bv, tx_first, tx_last;
  logic        tx_ctrl, rx_hv, rx_bv, rx_first, rx_last, rx_udp, rx_ctrl, rx_done, rx_disc;
  logic        tx_hv, tx_udp, tx_done, ce, e;
  logic [7:0]  avs_addr, tx_byte, rx_byte;
  logic [31:0] avs_wdata, avs_rdata, tx_fcs, seed, r, v;
  logic [15:0] tx_dst, tx_src, tx_csum, rx_port, rx_csum, p, c, o, k2;
  logic [1:0]  tx_kind;
  logic [2:0]  tx_sess;
  lupc_bytes_t q;
  int          n_fail, checks_done, nd;

  lupc_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .avs_address_in(avs_addr),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_wdata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_rdata), .avs_waitrequest_out(avs_wait),
    .rx_hdr_valid_in(rx_hv), .rx_is_sccrq_in(rx_hv), .rx_has_udp_in(rx_hv),
    .rx_src_port_in(rx_port), .rx_byte_valid_in(rx_bv), .rx_byte_in(rx_byte),
    .rx_first_in(rx_first), .rx_last_in(rx_last), .rx_in_udp_in(rx_udp),
    .rx_is_ctrl_in(rx_ctrl), .rx_csum_in(rx_csum), .rx_done_out(rx_done),
    .rx_discard_out(rx_disc), .tx_req_in(tx_req), .tx_kind_in(tx_kind), .tx_sess_in(tx_sess),
    .tx_hdr_valid_out(tx_hv), .tx_udp_out(tx_udp), .tx_dst_port_out(tx_dst),
    .tx_src_port_out(tx_src), .tx_byte_valid_in(tx_bv), .tx_byte_in(tx_byte),
    .tx_first_in(tx_first), .tx_last_in(tx_last), .tx_in_udp_in(tx_bv),
    .tx_is_ctrl_in(tx_ctrl), .tx_done_out(tx_done), .tx_csum_out(tx_csum), .tx_fcs_out(tx_fcs));
  lupc_core_model core_u (.clk_in(clk_in), .hdr_valid_out(rx_hv), .src_port_out(rx_port),
    .byte_valid_out(rx_bv), .byte_out(rx_byte), .first_out(rx_first), .last_out(rx_last),
    .in_udp_out(rx_udp), .is_ctrl_out(rx_ctrl), .csum_out(rx_csum));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic lupc_bytes_t mk(input int n);
    lupc_bytes_t b;
    b = {8'h00, 8'h00};
    repeat (n) b.push_back(8'(rnd()));
    return b;
  endfunction
  // Checksum of a zeroed field; zero result sent as all ones
  function automatic logic [15:0] sum(input lupc_bytes_t b);
    logic [31:0] s;
    s = 32'h0;
    foreach (b[i]) s += i[0] ? {24'h0, b[i]} : {16'h0, b[i], 8'h00};
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    return (s[15:0] == 16'hffff) ? 16'hffff : ~s[15:0];
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a one-cycle pulse
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    #1;
    while (s !== 1'b1 && k < 20) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    if (k >= 20) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    avs_write <= wr;
    avs_read  <= !wr;
    avs_addr  <= a;
    avs_wdata <= d;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (avs_wait !== 1'b0 && k < 50);
    r = avs_rdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      close_out();
    end
    @(posedge clk_in);
  endtask
  task automatic hdr(input logic [1:0] kd, input int s, input logic [15:0] d, input logic [15:0] sr);
    tx_req  <= 1'b1;
    tx_kind <= kd;
    tx_sess <= 3'(s);
    @(posedge clk_in);
    tx_req <= 1'b0;
    #1;
    chk({tx_hv, tx_udp, tx_dst, tx_src}, {2'b11, d, sr});
    @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    {rst_in, avs_read, avs_write, tx_req, tx_bv, tx_first, tx_last, tx_ctrl} = 8'h80;
    ce = 1'b1;
    {avs_addr, avs_wdata, tx_byte, tx_kind, tx_sess} = '0;
    seed = 32'hcdd8;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    bus(0, LUPC_OFF_PORTS, 0);
    chk(r, {LUPC_WELL_KNOWN_PORT, LUPC_WELL_KNOWN_PORT});
    bus(0, LUPC_OFF_MCAST, 0);
    chk(r, {LUPC_MCAST_HI_RST, LUPC_MCAST_LO_RST});
    bus(0, 8'hfc, 0);
    chk(r, 0);
    bus(1, LUPC_OFF_CTRL, 32'h1);
    p = {4'h5, 12'(rnd())};
    core_u.sccrq(p);
    bus(0, LUPC_OFF_CTRL, 0);
    chk(r[8], 1'b1);
    hdr(LUPC_KIND_SCCRP, 0, p, LUPC_WELL_KNOWN_PORT);
    // Port in the multicast range is refused and flagged
    bus(1, LUPC_OFF_MCAST, 32'h2000_1000);
    bus(1, LUPC_OFF_PORTS, 32'h0000_1800);
    bus(0, LUPC_OFF_STATUS, 0);
    chk(r[0], 1'b1);
    bus(0, LUPC_OFF_PORTS, 0);
    chk(r, {p, LUPC_WELL_KNOWN_PORT});
    bus(1, LUPC_OFF_STATUS, 32'h1);
    bus(1, LUPC_OFF_PORTS, 32'h0000_3000);
    hdr(LUPC_KIND_CTRL, 0, p, 16'h3000);
    // Clock enable low: a header request must not be taken
    ce     <= 1'b0;
    tx_req <= 1'b1;
    @(posedge clk_in);
    tx_req <= 1'b0;
    ce     <= 1'b1;
    #1;
    chk(tx_hv, 1'b0);
    @(posedge clk_in);
    for (int s = 0; s < 8; s++) begin
      o = {4'h4, 12'(rnd())};
      k2 = {4'h6, 12'(rnd())};
      bus(1, LUPC_OFF_SEL, 32'(s));
      bus(1, LUPC_OFF_SPORT, {k2, o});
      bus(1, LUPC_OFF_SFLAG, {30'h0, 2'(s)});
      hdr(LUPC_KIND_UP_DATA, s, s[1] ? k2 : p, s[0] ? o : 16'h3000);
      hdr(LUPC_KIND_DS_RETURN, s, s[1] ? k2 : p, s[0] ? o : 16'h3000);
    end
    // Own session port inside the multicast range is refused and flagged
    bus(1, LUPC_OFF_SPORT, {k2, 16'h1800});
    bus(0, LUPC_OFF_SPORT, 0);
    chk(r, {k2, o});
    bus(0, LUPC_OFF_STATUS, 0);
    chk(r, 32'h00000001);
    bus(1, LUPC_OFF_STATUS, 32'h1);
    // Received frames: random mode, auth, transport and checksum fault
    for (int m = 0; m < 24; m++) begin
      v = rnd();
      bus(1, LUPC_OFF_CTRL, {29'h0, v[2:1], 1'b1});
      q = mk(2 + int'(v[7:4]));
      c = sum(q);
      if (v[9:8] == 2'd1) c = 16'h0;
      if (v[9:8] == 2'd2) c = c ^ 16'h8000;
      q[0] = c[15:8];
      q[1] = c[7:0];
      core_u.frame(q, v[3], v[10] & v[11]);
      wait_hi(rx_done);
      e = (v[10] & v[11]) | (v[9:8] == 2'd2 && c != 0 && (v[3] | v[2]))
        | (c == 0 && v[3] && !v[1]);
      chk(rx_disc, e);
      nd += e;
      @(posedge clk_in);
    end
    // Every dropped frame is counted
    bus(0, LUPC_OFF_STATUS, 0);
    chk(r, {16'(nd), 16'h0000});
    // Sent frames: checksum field fed as zero
    for (int m = 0; m < 12; m++) begin
      v = rnd();
      bus(1, LUPC_OFF_CTRL, {29'h0, v[2:1], 1'b1});
      q = mk(1 + int'(v[7:4]));
      foreach (q[i]) begin
        tx_bv    <= 1'b1;
        tx_byte  <= q[i];
        tx_first <= (i == 0);
        tx_last  <= (i == q.size() - 1);
        tx_ctrl  <= v[3];
        @(posedge clk_in);
      end
      tx_bv   <= 1'b0;
      tx_last <= 1'b0;
      tx_byte <= ~tx_byte;
      wait_hi(tx_done);
      c = (v[3] && !(v[1] && !v[2])) ? sum(q) : 16'h0;
      chk({tx_csum, tx_fcs}, {c, core_u.fcs(q)});
      @(posedge clk_in);
    end
    close_out();
  end
endmodule
`default_nettype wire
